// ===== logic/status_words_params.svh
// Offsets, field positions, reset values and codes of the serial board status words
`ifndef STATUS_WORDS_PARAMS_SVH
`define STATUS_WORDS_PARAMS_SVH

// Word indices; byte address is four times the index
`define IDX_BOARD        8'hc8
`define IDX_PORT_ERR     8'hc9
`define IDX_CNT_ONE      8'hca
`define IDX_CNT_TWO      8'hcb
`define IDX_TRACE        8'hcc
`define IDX_MODE         8'hd0

// Board word
`define BIT_HW_FAULT     0
`define BIT_ID_FAIL      1
`define BIT_SEQ_DATA     2
`define BIT_UNUSED_LO    3
`define BIT_UNUSED_HI    10
`define BIT_EXEC_FAIL_P2 11
`define BIT_EXEC_FAIL_P1 12

// Port error word, port two sits one byte higher
`define PORT_SHIFT       8
`define ERR_CODE_LSB     0
`define BIT_COMM_ERR     4
`define BIT_TX_EN        5
`define BIT_RX_DONE      6
`define BIT_OVF_ABORT    7

// Trace, echo and sequence error word
`define BIT_TRACE_LSB    0
`define BIT_ECHO_LSB     6
`define SEQ_ERR_LSB      8
`define SEQ_ERR_STRIDE   4

// Reset values
`define RST_WORD         16'h0000
`define RST_MODE         4'h0

// Port error codes
`define ERR_NORMAL       4'h0
`define ERR_PARITY       4'h1
`define ERR_FRAMING      4'h2
`define ERR_OVERRUN      4'h3
`define ERR_FRAME_CHECK  4'h4
`define ERR_TIMEOUT      4'h5
`define ERR_CHECKSUM     4'h6
`define ERR_COMMAND      4'h7

// Sequence error codes
`define SEQ_NORMAL       4'h0
`define SEQ_NUMBER       4'h2
`define SEQ_GRAMMAR      4'h4
`define SEQ_DURING_INIT  4'h5

// Largest BCD digit
`define BCD_MAX_DIGIT    4'h9

`endif

// ===== logic/status_words_pkg.sv
// Types shared by the serial board status word bank
package status_words_pkg;

    typedef enum logic [1:0] {
        mode_host_link,
        mode_no_protocol,
        mode_sequence,
        terminal_link_mode
    } port_mode_t;

    typedef struct packed {
        logic hw_fault;
        logic id_fail;
        logic seq_data_fault;
        logic clear;
    } board_hw_t;

    typedef struct packed {
        logic       clear;
        logic       err_valid;
        logic [3:0] err_code;
        logic       comm_err;
        logic       tx_enabled;
        logic       rx_done;
        logic       rx_overflow;
        logic       abort_done;
        logic       exec_fail;
        logic       rx_byte;
        logic [7:0] terminal_active;
        logic       repeat_load;
        logic [7:0] repeat_value;
        logic       tracing;
        logic       echo_disabled;
        logic       seq_err_valid;
        logic [3:0] seq_err_code;
    } port_hw_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [11:0] address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } avalon_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } avalon_rsp_t;

endpackage

// ===== logic/bcd_rx_counter.sv
// Four digit BCD reception counter that wraps from 9999 to 0000
`timescale 1ns/1ps
module bcd_rx_counter
    import status_words_pkg::*;
#(
    parameter int DIGITS = 4
) (
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    input  wire logic                  clear,
    input  wire logic                  incr,
    output logic      [4*DIGITS-1:0]   count_q
);
    `include "status_words_params.svh"

    logic [4*DIGITS-1:0] count_d;
    logic                carry;

    always_comb begin
        count_d = count_q;
        carry   = incr;
        for (int i = 0; i < DIGITS; i++) begin
            if (carry) begin
                if (count_q[4*i +: 4] == `BCD_MAX_DIGIT) begin
                    count_d[4*i +: 4] = 4'h0;
                end else begin
                    count_d[4*i +: 4] = count_q[4*i +: 4] + 4'h1;
                    carry             = 1'b0;
                end
            end
        end
        // A byte in the clearing cycle still counts as the first one
        if (clear) begin
            count_d = {{(4*DIGITS-1){1'b0}}, incr};
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule // bcd_rx_counter

// ===== logic/avalon_wait_slave.sv
// Avalon-MM handshake: one wait cycle, then the access completes
`timescale 1ns/1ps
module avalon_wait_slave
    import status_words_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic read,
    input  wire logic write,
    output logic      waitrequest,
    output logic      take
);
    logic ack_q;
    logic ack_d;
    logic req;

    // The wait cycle gives the read mux a full cycle to register its word
    always_comb begin
        req         = read | write;
        ack_d       = req & ~ack_q;
        waitrequest = req & ~ack_q;
        take        = req & ack_q;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

endmodule // avalon_wait_slave

// ===== logic/status_word_bank.sv
// Status word bank of a two-port serial communications board
//
// Behaviour
// - Board fault sets bit 0, port id failure bit 1, sequence data fault bit 2.
// - Sequence execution failure: bit 12 for port one, bit 11 for port two.
// - Each port shows a 4-bit error code; codes 0 to 7 as listed.
// - In sequence mode bit 7 / bit 15 show abort completed.
// - Terminal link mode: counter word bits 0-7 show terminals 0-7 active.
// - Sequence mode: counter word low byte holds repeat counter present value.
// - No-protocol mode: counter word holds reception count as four BCD digits.
// - Echoback disabled shown in bit 6 port one, bit 7 port two.
// - Per-port 4-bit sequence error code in bits 8-11 and 12-15.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module status_word_bank
    import status_words_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire avalon_req_t       bus_req,
    output avalon_rsp_t            bus_rsp,
    input  wire board_hw_t         board_hw,
    input  wire port_hw_t    [1:0] port_hw,
    output port_mode_t       [1:0] port_mode
);
    `include "status_words_params.svh"

    function automatic logic is_word(input logic [11:0] addr, input logic [7:0] idx);
        is_word = (addr == {2'b00, idx, 2'b00});
    endfunction

    function automatic logic legal_err(input logic [3:0] code);
        legal_err = (code <= `ERR_COMMAND);
    endfunction

    function automatic logic legal_seq(input logic [3:0] code);
        legal_seq = (code == `SEQ_NORMAL) || (code == `SEQ_NUMBER) ||
                    (code == `SEQ_GRAMMAR) || (code == `SEQ_DURING_INIT);
    endfunction

    function automatic logic [15:0] counter_word(input port_mode_t mode,
                                                 input logic [7:0] term,
                                                 input logic [7:0] rep,
                                                 input logic [15:0] bcd);
        case (mode)
            terminal_link_mode: counter_word = {8'h00, term};
            mode_sequence:      counter_word = {8'h00, rep};
            mode_no_protocol:   counter_word = bcd;
            default:            counter_word = `RST_WORD;
        endcase
    endfunction

    // Bus handshake
    logic waitrequest;
    logic take;

    avalon_wait_slave u_slave (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .read        (bus_req.read),
        .write       (bus_req.write),
        .waitrequest (waitrequest),
        .take        (take)
    );

    // Board level sticky flags
    logic       hw_fault_q;
    logic       hw_fault_d;
    logic       id_fail_q;
    logic       id_fail_d;
    logic       seq_data_q;
    logic       seq_data_d;

    always_comb begin
        // Set wins over a clear in the same cycle
        hw_fault_d = board_hw.hw_fault | (hw_fault_q & ~board_hw.clear);
        id_fail_d  = board_hw.id_fail | (id_fail_q & ~board_hw.clear);
        seq_data_d = board_hw.seq_data_fault | (seq_data_q & ~board_hw.clear);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hw_fault_q <= 1'b0;
            id_fail_q  <= 1'b0;
            seq_data_q <= 1'b0;
        end else begin
            hw_fault_q <= hw_fault_d;
            id_fail_q  <= id_fail_d;
            seq_data_q <= seq_data_d;
        end
    end

    // Per-port state
    logic [1:0][3:0]  err_code_q;
    logic [1:0][3:0]  err_code_d;
    logic [1:0]       comm_err_q;
    logic [1:0]       comm_err_d;
    logic [1:0]       rx_done_q;
    logic [1:0]       rx_done_d;
    logic [1:0]       rx_ovf_q;
    logic [1:0]       rx_ovf_d;
    logic [1:0]       abort_q;
    logic [1:0]       abort_d;
    logic [1:0]       exec_fail_q;
    logic [1:0]       exec_fail_d;
    logic [1:0][7:0]  repeat_q;
    logic [1:0][7:0]  repeat_d;
    logic [1:0][3:0]  seq_err_q;
    logic [1:0][3:0]  seq_err_d;
    logic [1:0][15:0] bcd_count;

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            err_code_d[p]  = port_hw[p].clear ? `ERR_NORMAL : err_code_q[p];
            // Codes outside the list are dropped so the field never shows junk
            if (port_hw[p].err_valid && legal_err(port_hw[p].err_code)) begin
                err_code_d[p] = port_hw[p].err_code;
            end
            comm_err_d[p]  = port_hw[p].comm_err | (comm_err_q[p] & ~port_hw[p].clear);
            rx_done_d[p]   = port_hw[p].rx_done | (rx_done_q[p] & ~port_hw[p].clear);
            rx_ovf_d[p]    = port_hw[p].rx_overflow | (rx_ovf_q[p] & ~port_hw[p].clear);
            abort_d[p]     = port_hw[p].abort_done | (abort_q[p] & ~port_hw[p].clear);
            exec_fail_d[p] = port_hw[p].exec_fail | (exec_fail_q[p] & ~port_hw[p].clear);
            repeat_d[p]    = port_hw[p].repeat_load ? port_hw[p].repeat_value
                                                    : repeat_q[p];
            seq_err_d[p]   = port_hw[p].clear ? `SEQ_NORMAL : seq_err_q[p];
            if (port_hw[p].seq_err_valid && legal_seq(port_hw[p].seq_err_code)) begin
                seq_err_d[p] = port_hw[p].seq_err_code;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            err_code_q  <= '0;
            comm_err_q  <= '0;
            rx_done_q   <= '0;
            rx_ovf_q    <= '0;
            abort_q     <= '0;
            exec_fail_q <= '0;
            repeat_q    <= '0;
            seq_err_q   <= '0;
        end else begin
            err_code_q  <= err_code_d;
            comm_err_q  <= comm_err_d;
            rx_done_q   <= rx_done_d;
            rx_ovf_q    <= rx_ovf_d;
            abort_q     <= abort_d;
            exec_fail_q <= exec_fail_d;
            repeat_q    <= repeat_d;
            seq_err_q   <= seq_err_d;
        end
    end

    // Reception counters run only in no-protocol mode
    for (genvar p = 0; p < 2; p++) begin : g_port
        bcd_rx_counter #(.DIGITS(4)) u_bcd (
            .clk_sys (clk_sys),
            .reset_n (reset_n),
            .clear   (port_hw[p].clear),
            .incr    (port_hw[p].rx_byte && port_mode[p] == mode_no_protocol),
            .count_q (bcd_count[p])
        );
    end

    // Mode register, the only word that software may write
    logic [3:0] mode_q;
    logic [3:0] mode_d;

    always_comb begin
        mode_d = mode_q;
        // Status word addresses are never decoded for writes, so they stay read-only
        if (take && bus_req.write && bus_req.byteenable[0] &&
            is_word(bus_req.address, `IDX_MODE)) begin
            mode_d = bus_req.writedata[3:0];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= `RST_MODE;
        end else begin
            mode_q <= mode_d;
        end
    end

    assign port_mode[0] = port_mode_t'(mode_q[1:0]);
    assign port_mode[1] = port_mode_t'(mode_q[3:2]);

    // Status words as seen by the processor
    logic [15:0] w_board;
    logic [15:0] w_port_err;
    logic [15:0] w_cnt [2];
    logic [15:0] w_trace;

    always_comb begin
        w_board                    = `RST_WORD;
        w_board[`BIT_HW_FAULT]     = hw_fault_q;
        w_board[`BIT_ID_FAIL]      = id_fail_q;
        w_board[`BIT_SEQ_DATA]     = seq_data_q;
        w_board[`BIT_EXEC_FAIL_P1] = exec_fail_q[0];
        w_board[`BIT_EXEC_FAIL_P2] = exec_fail_q[1];
        w_port_err = `RST_WORD;
        w_trace    = `RST_WORD;
        for (int p = 0; p < 2; p++) begin
            w_port_err[`PORT_SHIFT*p + `ERR_CODE_LSB +: 4] = err_code_q[p];
            w_port_err[`PORT_SHIFT*p + `BIT_COMM_ERR]      = comm_err_q[p];
            w_port_err[`PORT_SHIFT*p + `BIT_TX_EN]         = port_hw[p].tx_enabled;
            w_port_err[`PORT_SHIFT*p + `BIT_RX_DONE]       = rx_done_q[p];
            // The top bit of each byte changes meaning with the mode
            w_port_err[`PORT_SHIFT*p + `BIT_OVF_ABORT] =
                (port_mode[p] == mode_sequence) ? abort_q[p] : rx_ovf_q[p];
            w_cnt[p] = counter_word(port_mode[p], port_hw[p].terminal_active,
                                    repeat_q[p], bcd_count[p]);
            w_trace[`BIT_TRACE_LSB + p] = port_hw[p].tracing;
            w_trace[`BIT_ECHO_LSB + p]  = port_hw[p].echo_disabled;
            w_trace[`SEQ_ERR_LSB + `SEQ_ERR_STRIDE*p +: 4] = seq_err_q[p];
        end
    end

    // Read data is registered in the wait cycle and stands at the completing edge
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (bus_req.read && waitrequest) begin
            rdata_d = `RST_WORD;
            if (is_word(bus_req.address, `IDX_BOARD))    rdata_d = w_board;
            if (is_word(bus_req.address, `IDX_PORT_ERR)) rdata_d = w_port_err;
            if (is_word(bus_req.address, `IDX_CNT_ONE))  rdata_d = w_cnt[0];
            if (is_word(bus_req.address, `IDX_CNT_TWO))  rdata_d = w_cnt[1];
            if (is_word(bus_req.address, `IDX_TRACE))    rdata_d = w_trace;
            if (is_word(bus_req.address, `IDX_MODE))     rdata_d = {12'h000, mode_q};
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= `RST_WORD;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign bus_rsp.readdata    = {16'h0000, rdata_q};
    assign bus_rsp.waitrequest = waitrequest;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_read_wait;
        bus_req.read && waitrequest;
    endsequence

    sequence s_read_done;
        bus_req.read && !waitrequest;
    endsequence

    a_hw_fault_sticky: assert property (
        board_hw.hw_fault |=> (w_board[`BIT_HW_FAULT] and
        (!board_hw.clear |=> w_board[`BIT_HW_FAULT])))
        else $error("board fault flag did not set or did not hold");

    a_id_seq_flags: assert property (
        (board_hw.id_fail |=> w_board[`BIT_ID_FAIL]) and
        (board_hw.seq_data_fault |=> w_board[`BIT_SEQ_DATA]))
        else $error("board id or data fault flag wrong");

    a_exec_fail_bits: assert property (
        port_hw[1].exec_fail && !port_hw[0].exec_fail && !exec_fail_q[0] &&
        !port_hw[0].clear |=> w_board[`BIT_EXEC_FAIL_P2] && !w_board[`BIT_EXEC_FAIL_P1] &&
        w_board[`BIT_UNUSED_HI:`BIT_UNUSED_LO] == 8'h00)
        else $error("execution failure reported on the wrong port");

    a_err_code_latch: assert property (
        port_hw[0].err_valid && legal_err(port_hw[0].err_code) |=>
        w_port_err[3:0] == $past(port_hw[0].err_code))
        else $error("port one error code not captured");

    a_abort_in_seq: assert property (
        port_hw[1].abort_done && port_mode[1] == mode_sequence ##1
        $stable(mode_q) |-> w_port_err[`PORT_SHIFT + `BIT_OVF_ABORT])
        else $error("port two abort completion not shown");

    a_terminal_bits: assert property (
        port_mode[0] == terminal_link_mode |->
        w_cnt[0] == {8'h00, port_hw[0].terminal_active})
        else $error("terminal activity bits wrong");

    a_repeat_value: assert property (
        port_hw[1].repeat_load && port_mode[1] == mode_sequence ##1
        port_mode[1] == mode_sequence |-> w_cnt[1] == {8'h00, $past(port_hw[1].repeat_value)})
        else $error("repeat counter value wrong");

    a_bcd_digits: assert property (
        port_mode[0] == mode_no_protocol |->
        w_cnt[0][3:0] <= `BCD_MAX_DIGIT && w_cnt[0][7:4] <= `BCD_MAX_DIGIT &&
        w_cnt[0][11:8] <= `BCD_MAX_DIGIT && w_cnt[0][15:12] <= `BCD_MAX_DIGIT)
        else $error("reception count is not BCD");

    a_bcd_step: assert property (
        port_hw[0].rx_byte && port_mode[0] == mode_no_protocol && !port_hw[0].clear &&
        bcd_count[0][3:0] != `BCD_MAX_DIGIT |=> bcd_count[0][3:0] ==
        $past(bcd_count[0][3:0]) + 4'h1)
        else $error("reception count did not step");

    a_echo_bits: assert property (
        ##1 w_trace[`BIT_ECHO_LSB +: 2] == {port_hw[1].echo_disabled,
                                            port_hw[0].echo_disabled})
        else $error("echoback flags misplaced");

    a_seq_err_code: assert property (
        port_hw[1].seq_err_valid && legal_seq(port_hw[1].seq_err_code) |=>
        w_trace[15:12] == $past(port_hw[1].seq_err_code))
        else $error("port two sequence error code not captured");

    a_status_readonly: assert property (
        take && bus_req.write && !is_word(bus_req.address, `IDX_MODE) |=>
        $stable(mode_q))
        else $error("write to a status word changed state");

    a_read_timing: assert property (
        s_read_wait |=> s_read_done or !bus_req.read)
        else $error("read not answered after one wait cycle");

endmodule // status_word_bank

// ===== dv/status_word_bank_bench.sv
// Self-checking bench for the serial board status word bank
`timescale 1ns/1ps
module status_word_bank_bench;
    import status_words_pkg::*;
    logic                  clk_sys;
    logic                  reset_n;
    avalon_req_t           bus_req;
    avalon_rsp_t           bus_rsp;
    board_hw_t             board_hw;
    port_hw_t        [1:0] port_hw;
    port_hw_t        [1:0] lvl;
    port_mode_t      [1:0] port_mode;
    int                    fails;
    int                    check_count;
    logic           [31:0] rd;

    status_word_bank u_status_word_bank (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .bus_req   (bus_req),
        .bus_rsp   (bus_rsp),
        .board_hw  (board_hw),
        .port_hw   (port_hw),
        .port_mode (port_mode)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic final_report();
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Waitrequest and read data are taken at the rising edge, before that edge's updates land
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        bus_req.read       <= ~wr;
        bus_req.write      <= wr;
        bus_req.address    <= a;
        bus_req.writedata  <= wd;
        bus_req.byteenable <= 4'hf;
        do begin
            @(posedge clk_sys);
            n++;
        end while (bus_rsp.waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            fails++;
            final_report();
        end
        rd = bus_rsp.readdata;
        bus_req.read  <= 1'b0;
        bus_req.write <= 1'b0;
    endtask

    // Pulses last one edge; afterwards the live levels in lvl are driven again
    task automatic pulse(input port_hw_t a, input port_hw_t b, input board_hw_t bd);
        @(posedge clk_sys);
        port_hw  <= {b, a};
        board_hw <= bd;
        @(posedge clk_sys);
        port_hw  <= lvl;
        board_hw <= '0;
    endtask

    task automatic clr();
        port_hw_t c;
        c = '0;
        c.clear = 1'b1;
        pulse(c, c, board_hw_t'(4'h1));
    endtask

    task automatic t_reset_values();
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 12'h320 + 12'(i * 4), '0);
            chk("reset word", 32'h0000_0000, rd);
        end
        bus(1'b0, 12'h340, '0);
        chk("reset mode", 32'h0000_0000, rd);
    endtask

    task automatic t_board();
        port_hw_t a;
        a = '0;
        a.exec_fail = 1'b1;
        pulse(a, '0, '0);
        bus(1'b0, 12'h320, '0);
        chk("board word", 32'h0000_1000, rd);
        pulse('0, a, '0);
        bus(1'b0, 12'h320, '0);
        chk("board word", 32'h0000_1800, rd);
        // Fields run hw_fault, id_fail, seq_data_fault from the top bit down
        for (int k = 0; k < 3; k++) begin
            pulse('0, '0, board_hw_t'(4'h8 >> k));
            bus(1'b0, 12'h320, '0);
            chk("board word", 32'h0000_1800 | 32'((2 << k) - 1), rd);
        end
        clr();
        bus(1'b0, 12'h320, '0);
        chk("board cleared", 32'h0000_0000, rd);
    endtask

    task automatic t_err_codes();
        port_hw_t a;
        port_hw_t b;
        clr();
        a = '0;
        a.err_valid = 1'b1;
        b = a;
        // Last pass offers codes 8 and 15, which must not be latched
        for (int c = 0; c < 9; c++) begin
            a.err_code = 4'(c);
            b.err_code = 4'(7 - c);
            pulse(a, b, '0);
            bus(1'b0, 12'h324, '0);
            chk("error codes", (c < 8) ? {20'h0_0000, 4'(7 - c), 4'h0, 4'(c)} : 32'h0000_0007,
                rd);
        end
    endtask

    task automatic t_seq_mode();
        port_hw_t a;
        port_hw_t b;
        clr();
        bus(1'b1, 12'h340, 32'h0000_000a);
        // The mode register lands at the accepting edge, so look one edge later
        @(posedge clk_sys);
        chk("mode out", 32'h0000_000a, 32'(port_mode));
        a = '0;
        a.abort_done = 1'b1;
        a.repeat_load = 1'b1;
        a.repeat_value = 8'hff;
        b = a;
        b.repeat_value = 8'h01;
        pulse(a, b, '0);
        bus(1'b0, 12'h324, '0);
        chk("abort flags", 32'h0000_8080, rd);
        bus(1'b0, 12'h328, '0);
        chk("repeat one", 32'h0000_00ff, rd);
        bus(1'b0, 12'h32c, '0);
        chk("repeat two", 32'h0000_0001, rd);
    endtask

    task automatic t_terminal();
        bus(1'b1, 12'h340, 32'h0000_000f);
        lvl[0].terminal_active = 8'ha5;
        lvl[1].terminal_active = 8'h5a;
        pulse(lvl[0], lvl[1], '0);
        bus(1'b0, 12'h328, '0);
        chk("terminals one", 32'h0000_00a5, rd);
        bus(1'b0, 12'h32c, '0);
        chk("terminals two", 32'h0000_005a, rd);
        lvl = '0;
        pulse('0, '0, '0);
    endtask

    task automatic t_bcd();
        port_hw_t a;
        clr();
        bus(1'b1, 12'h340, 32'h0000_0005);
        @(posedge clk_sys);
        port_hw[0].rx_byte <= 1'b1;
        repeat (9999) @(posedge clk_sys);
        port_hw[0].rx_byte <= 1'b0;
        bus(1'b0, 12'h328, '0);
        chk("bcd one", 32'h0000_9999, rd);
        a = '0;
        a.rx_byte = 1'b1;
        pulse(a, a, '0);
        bus(1'b0, 12'h328, '0);
        chk("bcd wrap", 32'h0000_0000, rd);
        bus(1'b0, 12'h32c, '0);
        chk("bcd two", 32'h0000_0001, rd);
    endtask

    task automatic t_trace();
        port_hw_t a;
        port_hw_t b;
        logic [3:0] s [4] = '{4'h0, 4'h2, 4'h4, 4'h5};
        bus(1'b1, 12'h340, 32'h0000_000a);
        lvl[0].tracing = 1'b1;
        lvl[1].echo_disabled = 1'b1;
        a = lvl[0];
        b = lvl[1];
        a.seq_err_valid = 1'b1;
        b.seq_err_valid = 1'b1;
        // Fifth pass offers codes 3 and 1, which must not be latched
        for (int i = 0; i < 5; i++) begin
            a.seq_err_code = (i < 4) ? s[i] : 4'h3;
            b.seq_err_code = (i < 4) ? s[3 - i] : 4'h1;
            pulse(a, b, '0);
            bus(1'b0, 12'h330, '0);
            chk("trace word", (i < 4) ? {16'h0000, s[3 - i], s[i], 8'h81} : 32'h0000_0581,
                rd);
        end
    endtask

    task automatic t_read_only();
        logic [31:0] v;
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, 12'h320 + 12'(i * 4), '0);
            v = rd;
            bus(1'b1, 12'h320 + 12'(i * 4), 32'hffff_ffff);
            bus(1'b0, 12'h320 + 12'(i * 4), '0);
            chk("read only word", v, rd);
        end
        bus(1'b0, 12'h300, '0);
        chk("unmapped read", 32'h0000_0000, rd);
    endtask

    // Host link mode: top bit of each byte is the overflow flag, bit 5 stays live
    task automatic t_port_flags();
        port_hw_t a;
        bus(1'b1, 12'h340, 32'h0000_0000);
        lvl[0].tx_enabled = 1'b1;
        lvl[1].tx_enabled = 1'b1;
        a = lvl[0];
        a.comm_err = 1'b1;
        a.rx_done = 1'b1;
        a.rx_overflow = 1'b1;
        pulse(a, a, '0);
        bus(1'b0, 12'h324, '0);
        chk("port flags", 32'h0000_f0f0, rd);
        clr();
        bus(1'b0, 12'h324, '0);
        chk("port flags cleared", 32'h0000_2020, rd);
        lvl = '0;
        pulse('0, '0, '0);
    endtask

    initial begin
        reset_n     = 1'b0;
        bus_req     = '0;
        board_hw    = '0;
        port_hw     = '0;
        lvl         = '0;
        fails       = 0;
        check_count = 0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset_values();
        t_board();
        t_err_codes();
        t_seq_mode();
        t_terminal();
        t_bcd();
        t_trace();
        t_read_only();
        t_port_flags();
        final_report();
    end
endmodule // status_word_bank_bench
